// [hw/lin_consts.vh]
// register map, field positions, reset values and timing constants of the lin data block
`ifndef LIN_CONSTS_VH
`define LIN_CONSTS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL 32'h40001800
`define ADDR_RX 32'h40001804
`define ADDR_TX 32'h40001808
`define ADDR_HDR 32'h4000180c
`define ADDR_BAUD 32'h40001810
`define ADDR_IRQ_STAT 32'h40001820
`define ADDR_IRQ_CLR 32'h40001824
`define ADDR_IRQ_EN 32'h40001828

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_START_STOP 24
`define CTRL_UNLOCK 25
`define RX_START 8
`define RX_STOP 9
`define RX_SYNC 10
`define TX_START 8
`define TX_STOP 9
`define HDR_DEL_LO 16
`define HDR_DEL_HI 23
`define BAUD_AUTO_LO 16
`define BAUD_AUTO_HI 30
`define IRQ_OVR 4
`define IRQ_CLASH 5
`define IRQ_TXOFF 6
`define IRQ_IDLE 7

// ----------------------------------------------------------------
// reset values and frame timing
// ----------------------------------------------------------------
`define CTRL_BAUD_RST 15'h03e8
`define IDLE_START 1'b0
`define IDLE_STOP 1'b1
`define TICK_NS 7'h32
`define CLK_NS 7'h08
`define SUB_PER_BIT 19'h00010
`define SAMPLE_PHASE 4'h7
`define LAST_PHASE 4'hf
`define LAST_BIT 4'h9
`define BREAK_MIN 9'h0b0
`define LOW_SAT 9'h1ff
`define DEL_SAT 8'hff

`endif

// [hw/lin_rx_frame.v]
// receive framer and break/delimiter length meter for the lin data block
`timescale 1ns/1ns
`include "lin_consts.vh"

module lin_rx_frame
(
    input wire clock,
    input wire sys_rst,
    input wire line,
    input wire sub_tick,
    input wire enable,
    output reg byte_valid_r,
    output reg [7:0] byte_data_r,
    output reg start_bit_r,
    output reg stop_bit_r,
    output reg [8:0] brk_low_r,
    output reg [7:0] brk_del_r
);

localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_FRAME = 2'b10;

reg [1:0] state_r;
reg line_d_r;
reg [3:0] phase_r;
reg [3:0] bit_idx_r;
reg [8:0] low_cnt_r;
reg [7:0] del_cnt_r;
reg del_run_r;
wire fall = line_d_r & ~line;
wire rise = ~line_d_r & line;

// ----------------------------------------------------------------
// byte framer, sampled at mid bit
// ----------------------------------------------------------------
always @(posedge clock)
begin
    byte_valid_r <= 1'b0;
    line_d_r <= line;
    if (sys_rst)
    begin
        state_r <= ST_IDLE;
        phase_r <= 4'h0;
        bit_idx_r <= 4'h0;
        byte_data_r <= 8'h00;
        start_bit_r <= 1'b0;
        stop_bit_r <= 1'b0;
        line_d_r <= 1'b1;
    end
    else
    begin
        case (state_r)
            ST_IDLE:
            begin
                // locked path: no byte is taken while unlock is clear
                if (fall && enable) // RULE14
                begin
                    state_r <= ST_FRAME;
                    phase_r <= 4'h0;
                    bit_idx_r <= 4'h0;
                end
            end
            ST_FRAME:
            begin
                if (sub_tick)
                begin
                    phase_r <= phase_r + 4'h1;
                    if (phase_r == `SAMPLE_PHASE)
                    begin
                        if (bit_idx_r == 4'h0)
                        begin
                            start_bit_r <= line; // RULE2
                            // a glitch, not a start bit
                            if (line)
                                state_r <= ST_IDLE;
                        end
                        else if (bit_idx_r == `LAST_BIT)
                        begin
                            stop_bit_r <= line; // RULE2
                            byte_valid_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                        else
                            byte_data_r <= {line, byte_data_r[7:1]}; // RULE1
                    end
                    if (phase_r == `LAST_PHASE)
                        bit_idx_r <= bit_idx_r + 4'h1;
                end
            end
            default:
                state_r <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// break low phase and delimiter meters, in sixteenths of a bit
// ----------------------------------------------------------------
always @(posedge clock)
begin
    if (sys_rst)
    begin
        low_cnt_r <= 9'h000;
        del_cnt_r <= 8'h00;
        del_run_r <= 1'b0;
        brk_low_r <= 9'h000;
        brk_del_r <= 8'h00;
    end
    else
    begin
        if (fall)
            low_cnt_r <= 9'h000;
        else if (!line && sub_tick && low_cnt_r != `LOW_SAT)
            low_cnt_r <= low_cnt_r + 9'h001;
        // a long enough low phase is a new break: keep both lengths until the next
        if (rise && low_cnt_r >= `BREAK_MIN)
        begin
            brk_low_r <= low_cnt_r; // RULE7 RULE15
            del_run_r <= 1'b1;
            del_cnt_r <= 8'h00;
        end
        else if (del_run_r && fall)
        begin
            brk_del_r <= del_cnt_r; // RULE8 RULE15
            del_run_r <= 1'b0;
        end
        else if (del_run_r && sub_tick && del_cnt_r != `DEL_SAT)
            del_cnt_r <= del_cnt_r + 8'h01;
    end
end

endmodule

// [hw/lin_tx_frame.v]
// transmit framer for the lin data block: start bit, eight data bits lsb first, stop bit
`timescale 1ns/1ns
`include "lin_consts.vh"

module lin_tx_frame
(
    input wire clock,
    input wire sys_rst,
    input wire sub_tick,
    input wire load,
    input wire [7:0] data,
    input wire start_bit,
    input wire stop_bit,
    output reg line_r,
    output reg busy_r,
    output reg done_r
);

localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_SEND = 2'b10;

reg [1:0] state_r;
reg [9:0] shift_r;
reg [3:0] phase_r;
reg [3:0] bit_idx_r;

// ----------------------------------------------------------------
// shifter, one bit per sixteen sub ticks
// ----------------------------------------------------------------
always @(posedge clock)
begin
    done_r <= 1'b0;
    if (sys_rst)
    begin
        state_r <= ST_IDLE;
        shift_r <= 10'h3ff;
        phase_r <= 4'h0;
        bit_idx_r <= 4'h0;
        line_r <= 1'b1;
        busy_r <= 1'b0;
    end
    else
    begin
        case (state_r)
            ST_IDLE:
            begin
                line_r <= 1'b1;
                if (load)
                begin
                    shift_r <= {stop_bit, data, start_bit};
                    phase_r <= 4'h0;
                    bit_idx_r <= 4'h0;
                    busy_r <= 1'b1;
                    state_r <= ST_SEND;
                end
            end
            ST_SEND:
            begin
                line_r <= shift_r[0];
                if (sub_tick)
                begin
                    phase_r <= phase_r + 4'h1;
                    if (phase_r == `LAST_PHASE)
                    begin
                        shift_r <= {1'b1, shift_r[9:1]};
                        bit_idx_r <= bit_idx_r + 4'h1;
                        if (bit_idx_r == `LAST_BIT)
                        begin
                            busy_r <= 1'b0;
                            done_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
            end
            default:
                state_r <= ST_IDLE;
        endcase
    end
end

endmodule

// [hw/lin_data_timing_regs.v]
// apb register block for lin received data, transmit data, header timing and bit period
//
// Behaviour
// RULE1 - received data byte in receive bits 7..0
// RULE2 - sampled start bit 8, stop bit 9
// RULE3 - synchronised receive line level at bit 10
// RULE4 - unused register bits always read zero
// RULE5 - transmit byte written, reads back zero
// RULE6 - start/stop bits need unlock and halfword+
// RULE7 - break low length: whole 8..4, sixteenths 3..0
// RULE8 - delimiter: sixteenths 19..16, whole 23..20
// RULE9 - four enables gate four status sources
// RULE10 - read-only controller bit period, default 1000
// RULE11 - read-write autobaud bit period at 30..16
// RULE12 - software writes zero to bit 15
// RULE13 - override picks written start/stop, else 0/1
// RULE14 - unlock opens receive and transmit paths
// RULE15 - break lengths refresh on every new break
`timescale 1ns/1ns
`include "lin_consts.vh"

module lin_data_timing_regs
#(
    // sub ticks of quiet high line before bus inactive is flagged
    parameter IDLE_SUBTICKS = 400000
)
(
    input wire clock,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire serial_receive_line,
    output wire serial_transmit_line,
    output reg irq
);

// ----------------------------------------------------------------
// declarations
// ----------------------------------------------------------------
reg rx_meta_r;
reg rx_sync_r;
reg [6:0] base_acc_r;
reg base_tick_r;
reg [18:0] sub_acc_r;
reg sub_tick_r;
reg unlock_r;
reg start_stop_r;
reg [14:0] auto_baud_r;
reg tx_start_r;
reg tx_stop_r;
reg unread_r;
reg [7:4] irq_stat_r;
reg [7:4] irq_en_r;
reg [7:4] irq_stat_nxt;
reg [7:4] irq_event;
reg [18:0] idle_cnt_r;
reg idle_done_r;
reg tx_load_r;
reg [7:0] tx_byte_r;
reg [31:0] rd_word;
wire [14:0] ctrl_baud = `CTRL_BAUD_RST;
wire [18:0] period;
wire [6:0] base_sum;
wire [18:0] sub_sum;
wire rx_valid;
wire [7:0] rx_byte;
wire rx_start;
wire rx_stop;
wire [8:0] brk_low;
wire [7:0] brk_del;
wire tx_busy;
wire tx_done;
wire setup = psel & ~penable;
wire acc_done = psel & penable & pready;
wire wr_done = acc_done & pwrite & ~pslverr;
wire rd_done = acc_done & ~pwrite & ~pslverr;

// ----------------------------------------------------------------
// address decode, shared by read and write paths
// ----------------------------------------------------------------
function addr_known;
    input [31:0] a;
    begin
        addr_known = (a == `ADDR_CTRL) || (a == `ADDR_RX) || (a == `ADDR_TX) ||
            (a == `ADDR_HDR) || (a == `ADDR_BAUD) || (a == `ADDR_IRQ_STAT) ||
            (a == `ADDR_IRQ_CLR) || (a == `ADDR_IRQ_EN);
    end
endfunction

// ----------------------------------------------------------------
// receive line synchroniser
// ----------------------------------------------------------------
// first stage feeds only the second one
always @(posedge clock)
begin
    if (sys_rst)
    begin
        rx_meta_r <= 1'b1;
        rx_sync_r <= 1'b1;
    end
    else
    begin
        rx_meta_r <= serial_receive_line;
        rx_sync_r <= rx_meta_r; // RULE3
    end
end

// ----------------------------------------------------------------
// 50 ns base tick and sixteenth-of-bit tick
// ----------------------------------------------------------------
// fractional divider: 50 ns is not a whole number of 8 ns cycles,
// so ticks come 6 or 7 cycles apart but average exactly 50 ns
assign base_sum = base_acc_r + `CLK_NS;
// a nonzero autobaud value takes over from the controller period
assign period = (auto_baud_r != 15'h0000) ? {4'h0, auto_baud_r} : {4'h0, ctrl_baud}; // RULE11
assign sub_sum = sub_acc_r + `SUB_PER_BIT;

always @(posedge clock)
begin
    if (sys_rst)
    begin
        base_acc_r <= 7'h00;
        base_tick_r <= 1'b0;
        sub_acc_r <= 19'h00000;
        sub_tick_r <= 1'b0;
    end
    else
    begin
        if (base_sum >= `TICK_NS)
        begin
            base_acc_r <= base_sum - `TICK_NS;
            base_tick_r <= 1'b1;
        end
        else
        begin
            base_acc_r <= base_sum;
            base_tick_r <= 1'b0;
        end
        // periods below 16 counts lose sub ticks: far beyond any lin rate
        sub_tick_r <= 1'b0;
        if (base_tick_r)
        begin
            if (sub_sum >= period)
            begin
                sub_acc_r <= sub_sum - period; // RULE10
                sub_tick_r <= 1'b1;
            end
            else
                sub_acc_r <= sub_sum;
        end
    end
end

// ----------------------------------------------------------------
// framers
// ----------------------------------------------------------------
lin_rx_frame u_rx
(
    .clock(clock),
    .sys_rst(sys_rst),
    .line(rx_sync_r),
    .sub_tick(sub_tick_r),
    .enable(unlock_r),
    .byte_valid_r(rx_valid),
    .byte_data_r(rx_byte),
    .start_bit_r(rx_start),
    .stop_bit_r(rx_stop),
    .brk_low_r(brk_low),
    .brk_del_r(brk_del)
);

lin_tx_frame u_tx
(
    .clock(clock),
    .sys_rst(sys_rst),
    .sub_tick(sub_tick_r),
    .load(tx_load_r),
    .data(tx_byte_r),
    .start_bit(start_stop_r ? tx_start_r : `IDLE_START), // RULE13
    .stop_bit(start_stop_r ? tx_stop_r : `IDLE_STOP), // RULE13
    .line_r(serial_transmit_line),
    .busy_r(tx_busy),
    .done_r(tx_done)
);

// ----------------------------------------------------------------
// apb handshake: one wait-free access phase after setup
// ----------------------------------------------------------------
always @(posedge clock)
begin
    if (sys_rst)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        pready <= setup;
        pslverr <= setup & ~addr_known(paddr);
        // read data is captured at setup so that it leaves a flop
        prdata <= (setup & ~pwrite) ? rd_word : 32'h00000000;
    end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
// every bit not named below reads zero
always @*
begin
    rd_word = 32'h00000000; // RULE4
    case (paddr)
        `ADDR_CTRL:
        begin
            rd_word[`CTRL_START_STOP] = start_stop_r;
            rd_word[`CTRL_UNLOCK] = unlock_r;
        end
        `ADDR_RX:
        begin
            rd_word[7:0] = rx_byte; // RULE1
            rd_word[`RX_START] = rx_start; // RULE2
            rd_word[`RX_STOP] = rx_stop; // RULE2
            rd_word[`RX_SYNC] = rx_sync_r; // RULE3
        end
        `ADDR_TX:
            rd_word = 32'h00000000; // RULE5
        `ADDR_HDR:
        begin
            rd_word[8:0] = brk_low; // RULE7
            rd_word[`HDR_DEL_HI:`HDR_DEL_LO] = brk_del; // RULE8
        end
        `ADDR_BAUD:
        begin
            rd_word[14:0] = ctrl_baud; // RULE10
            rd_word[`BAUD_AUTO_HI:`BAUD_AUTO_LO] = auto_baud_r; // RULE11
        end
        `ADDR_IRQ_STAT:
            rd_word[7:4] = irq_stat_r;
        `ADDR_IRQ_EN:
            rd_word[7:4] = irq_en_r;
        default:
            rd_word = 32'h00000000;
    endcase
end

// ----------------------------------------------------------------
// software-written settings
// ----------------------------------------------------------------
always @(posedge clock)
begin
    if (sys_rst)
    begin
        unlock_r <= 1'b0;
        start_stop_r <= 1'b0;
        auto_baud_r <= 15'h0000;
        irq_en_r <= 4'h0;
    end
    else if (wr_done)
    begin
        if (paddr == `ADDR_CTRL && pstrb[3])
        begin
            start_stop_r <= pwdata[`CTRL_START_STOP];
            unlock_r <= pwdata[`CTRL_UNLOCK]; // RULE14
        end
        // bit 15 and bit 31 are not stored; zero is expected there
        if (paddr == `ADDR_BAUD)
        begin
            if (pstrb[2])
                auto_baud_r[7:0] <= pwdata[23:16]; // RULE11 RULE12
            if (pstrb[3])
                auto_baud_r[14:8] <= pwdata[30:24]; // RULE11
        end
        if (paddr == `ADDR_IRQ_EN && pstrb[0])
            irq_en_r <= pwdata[7:4]; // RULE9
    end
end

// ----------------------------------------------------------------
// transmit register: load the framer when it is free
// ----------------------------------------------------------------
always @(posedge clock)
begin
    tx_load_r <= 1'b0;
    if (sys_rst)
    begin
        tx_byte_r <= 8'h00;
        tx_start_r <= `IDLE_START;
        tx_stop_r <= `IDLE_STOP;
    end
    else if (wr_done && paddr == `ADDR_TX && unlock_r && !tx_busy && !tx_load_r)
    begin
        if (pstrb[0])
        begin
            tx_byte_r <= pwdata[7:0]; // RULE5
            tx_load_r <= 1'b1;
        end
        // a byte write cannot touch the framing bits
        if (pstrb[1:0] == 2'b11)
        begin
            tx_start_r <= pwdata[`TX_START]; // RULE6
            tx_stop_r <= pwdata[`TX_STOP]; // RULE6
        end
    end
end

// ----------------------------------------------------------------
// bus inactive detector on the synchronised line
// ----------------------------------------------------------------
always @(posedge clock)
begin
    if (sys_rst)
    begin
        idle_cnt_r <= 19'h00000;
        idle_done_r <= 1'b0;
    end
    else if (!rx_sync_r)
    begin
        idle_cnt_r <= 19'h00000;
        idle_done_r <= 1'b0;
    end
    else if (sub_tick_r && !idle_done_r)
    begin
        if (idle_cnt_r == IDLE_SUBTICKS[18:0] - 19'h00001)
            idle_done_r <= 1'b1;
        idle_cnt_r <= idle_cnt_r + 19'h00001;
    end
end

// ----------------------------------------------------------------
// interrupt status: events set, clear register clears, set wins
// ----------------------------------------------------------------
always @*
begin
    irq_event = 4'h0;
    irq_event[`IRQ_OVR] = rx_valid & unread_r & ~(rd_done & (paddr == `ADDR_RX));
    irq_event[`IRQ_CLASH] = wr_done & (paddr == `ADDR_TX) & (tx_busy | tx_load_r);
    irq_event[`IRQ_TXOFF] = tx_done;
    irq_event[`IRQ_IDLE] = sub_tick_r & rx_sync_r & ~idle_done_r &
        (idle_cnt_r == IDLE_SUBTICKS[18:0] - 19'h00001);
    irq_stat_nxt = irq_stat_r;
    if (wr_done && paddr == `ADDR_IRQ_CLR && pstrb[0])
        irq_stat_nxt = irq_stat_r & ~pwdata[7:4];
    irq_stat_nxt = irq_stat_nxt | irq_event;
end

// the interrupt follows the status flop, so it lags the status by one cycle and events by two
always @(posedge clock)
begin
    if (sys_rst)
    begin
        irq_stat_r <= 4'h0;
        unread_r <= 1'b0;
        irq <= 1'b0;
    end
    else
    begin
        irq_stat_r <= irq_stat_nxt;
        irq <= |(irq_stat_r & irq_en_r); // RULE9
        // a fresh byte keeps the unread mark even during a read
        if (rx_valid)
            unread_r <= 1'b1;
        else if (rd_done && paddr == `ADDR_RX)
            unread_r <= 1'b0;
    end
end

endmodule

// [tb/lin_data_timing_regs_assertions.sv]
// assertion checker for the lin data register block
`timescale 1ns/1ns
`include "lin_consts.vh"
module lin_data_timing_regs_assertions
(
    input logic clock,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic serial_receive_line,
    input logic serial_transmit_line,
    input logic irq
);
    // ------------------------------------------------------------
    // apb answers and read fields
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire rd = pready && !pwrite;
    logic [4:0] hist;
    // line history, so bit 10 is only judged while the line is steady
    always @(posedge clock)
    begin
        hist <= {hist[3:0], serial_receive_line};
    end
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("answer without setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error outside access");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    rx_unused_a: assert property (rd && paddr == `ADDR_RX |-> prdata[31:11] == 21'h0)
        else $error("receive upper bits not zero");
    tx_zero_a: assert property (rd && paddr == `ADDR_TX |-> prdata == 32'h0)
        else $error("transmit register reads nonzero");
    baud_fixed_a: assert property (rd && paddr == `ADDR_BAUD |->
        prdata[15:0] == 16'h03e8 && !prdata[31]) else $error("bit period low half wrong");
    hdr_unused_a: assert property (rd && paddr == `ADDR_HDR |->
        prdata[15:9] == 7'h0 && prdata[31:24] == 8'h0) else $error("header unused bits");
    rx_sync_a: assert property (rd && paddr == `ADDR_RX && (hist == 5'h0 || hist == 5'h1f)
        |-> prdata[10] == hist[0]) else $error("synced line level wrong");
    rst_idle_a: assert property (disable iff (1'b0) sys_rst |=>
        !irq && serial_transmit_line && !pready) else $error("outputs not idle in reset");
endmodule
bind lin_data_timing_regs lin_data_timing_regs_assertions u_lin_data_timing_regs_assertions (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_receive_line(serial_receive_line),
    .serial_transmit_line(serial_transmit_line), .irq(irq));

// [tb/lin_master_model.sv]
// lin bus master model driving the receive line of the block
`timescale 1ns/1ns
module lin_master_model
#(
    parameter BIT_CYC = 100
)
(
    input wire clock,
    output reg line
);
    // bus idles recessive high through the pull-up
    initial line = 1'b1;
    // byte field: start low, data lsb first, stop high
    task send_frame(input [7:0] d);
        integer i;
        begin
            for (i = 0; i < 10; i = i + 1)
            begin
                line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
                repeat (BIT_CYC) @(posedge clock);
            end
        end
    endtask
    // break low phase then delimiter, lengths in clock cycles
    task send_break(input integer lo, input integer hi);
        begin
            line <= 1'b0;
            repeat (lo) @(posedge clock);
            line <= 1'b1;
            repeat (hi) @(posedge clock);
        end
    endtask
endmodule

// [tb/lin_data_timing_regs_test.sv]
// self-checking testbench for the lin data register block
`timescale 1ns/1ns
`include "lin_consts.vh"
`define CHK(n, e, g) begin checks_done = checks_done + 1; if ((g) !== (e)) \
    begin miscompares = miscompares + 1; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module lin_data_timing_regs_test;
    reg clock = 0;
    reg sys_rst = 1;
    reg psel = 0, penable = 0, pwrite = 0;
    reg [31:0] paddr = 0, pwdata = 0;
    reg [3:0] pstrb = 0;
    wire [31:0] prdata;
    wire pready, pslverr, rx_line, tx_line, irq;
    integer miscompares = 0, checks_done = 0, seed, i;
    reg [31:0] rd;
    reg err;
    reg [7:0] d;
    reg [9:0] fr;
    always #4 clock = ~clock;
    lin_data_timing_regs #(.IDLE_SUBTICKS(64)) u_lin_data_timing_regs (.clock(clock),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_receive_line(rx_line), .serial_transmit_line(tx_line), .irq(irq));
    lin_master_model #(.BIT_CYC(100)) u_lin_master_model (.clock(clock), .line(rx_line));
    // ------------------------------------------------------------
    // bus, line and verdict helpers
    // ------------------------------------------------------------
    task apb(input w, input [31:0] a, input [31:0] wd, input [3:0] s);
        integer n;
        begin
            @(posedge clock);
            psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= s;
            @(posedge clock);
            penable <= 1;
            n = 0;
            @(posedge clock);
            while (pready !== 1'b1 && n < 20)
            begin
                n = n + 1;
                @(posedge clock);
            end
            if (pready !== 1'b1)
                miscompares = miscompares + 1;
            rd = prdata;
            err = pslverr;
            psel <= 0; penable <= 0;
        end
    endtask
    task rchk(input string nm, input [31:0] a, input [31:0] m, input [31:0] e);
        begin
            apb(0, a, 32'h0, 4'h0);
            `CHK(nm, e, rd & m)
        end
    endtask
    // sample the sent frame at mid bit, start bit first
    task grab;
        integer n;
        begin
            n = 0;
            while (tx_line !== 1'b0 && n < 400)
            begin
                n = n + 1;
                @(posedge clock);
            end
            repeat (50) @(posedge clock);
            for (n = 0; n < 10; n = n + 1)
            begin
                fr[n] = tx_line;
                repeat (100) @(posedge clock);
            end
        end
    endtask
    // start and stop are written as 0, so only the override lets a low stop through
    function [9:0] exp_fr(input ov, input [7:0] dd);
        exp_fr = {~ov, dd, 1'b0};
    endfunction
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // watchdog well beyond the expected run of about 13000 cycles
    initial
    begin
        repeat (60000) @(posedge clock);
        miscompares = miscompares + 1;
        end_of_test;
    end
    // main sequence
    initial
    begin
        seed = 32'h4fb43111;
        repeat (20) @(posedge clock);
        sys_rst <= 0;
        repeat (6) @(posedge clock);
        rchk("rx", `ADDR_RX, 32'hfffffc00, 32'h400);
        rchk("tx", `ADDR_TX, 32'hffffffff, 32'h0);
        rchk("hdr", `ADDR_HDR, 32'hffffffff, 32'h0);
        rchk("baud", `ADDR_BAUD, 32'hffffffff, 32'h3e8);
        rchk("irq_en", `ADDR_IRQ_EN, 32'hffffffff, 32'h0);
        apb(0, 32'h40001830, 32'h0, 4'h0);
        `CHK("slverr", 1'b1, err)
        apb(1, `ADDR_BAUD, 32'h00107fff, 4'hf);
        rchk("baud", `ADDR_BAUD, 32'hffffffff, 32'h001003e8);
        apb(1, `ADDR_CTRL, 32'h02000000, 4'hf);
        for (i = 0; i < 4; i = i + 1)
        begin
            d = (i == 0) ? 8'h00 : $random(seed);
            u_lin_master_model.send_frame(d);
            rchk("rx", `ADDR_RX, 32'hffffffff, {21'h0, 3'b110, d});
        end
        apb(1, `ADDR_IRQ_EN, 32'h40, 4'h1);
        for (i = 0; i < 3; i = i + 1)
        begin
            d = $random(seed);
            apb(1, `ADDR_CTRL, {6'h0, 1'b1, i != 0, 24'h0}, 4'hf);
            // last pass is a byte write: its framing bits must be ignored
            fork
                grab;
                apb(1, `ADDR_TX, {22'h0, {2{i == 2}}, d}, {2'b00, i != 2, 1'b1});
            join
            `CHK("frame", exp_fr(i != 0, d), fr)
        end
        repeat (10) @(posedge clock);
        `CHK("irq", 1'b1, irq)
        rchk("status", `ADDR_IRQ_STAT, 32'hf0, 32'hc0);
        apb(1, `ADDR_IRQ_CLR, 32'hf0, 4'h1);
        repeat (3) @(posedge clock);
        `CHK("irq", 1'b0, irq)
        for (i = 0; i < 2; i = i + 1)
        begin
            u_lin_master_model.send_break(1250 + 400 * i, 250 + 200 * i);
            u_lin_master_model.send_frame(8'h55);
            apb(0, `ADDR_HDR, 32'h0, 4'h0);
            `CHK("low_whole", 12 + 4 * i, rd[8:4])
            `CHK("del_whole", 2 + 2 * i, rd[23:20])
        end
        // break byte and the following byte both land unread
        rchk("status", `ADDR_IRQ_STAT, 32'h10, 32'h10);
        end_of_test;
    end
endmodule
